// [src/cgw_pkg.sv]
// package of constants and types for the mode-gated clock generator write gate
// assumes one clock domain; register indices are byte-wide entries behind a serial decoder
//
// Notes on behaviour
// RQ1: outputs toggle only in active mode
// RQ2: active mode blocks most configuration writes
// RQ3: gated registers written only in ready mode
// RQ4: ready mode holds every output stopped
// RQ5: restart uses values written during ready
// RQ6: mode, spread, enables, input select always writable
// RQ7: readable status reports active or ready
// RQ8: host enters ready, checks status, then writes
// RQ9: host returns active, then checks status
// RQ10: host must not trust gating against strays
// RQ11: blocked writes still complete normally
package cgw_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned CGW_NUM_REGS = 16;
   localparam int unsigned CGW_ADDR_W   = 4;
   localparam int unsigned CGW_DATA_W   = 8;
   localparam int unsigned CGW_NUM_OUT  = 4;
   localparam int unsigned CGW_INSEL_W  = 2;

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [3:0] CGW_OFS_MODE     = 4'h0;
   localparam logic [3:0] CGW_OFS_STATUS   = 4'h1;
   localparam logic [3:0] CGW_OFS_SSC      = 4'h2;
   localparam logic [3:0] CGW_OFS_OE       = 4'h3;
   localparam logic [3:0] CGW_OFS_INSEL    = 4'h4;
   localparam logic [3:0] CGW_OFS_DIV_BASE = 4'h5;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CGW_MODE_ACTIVE_BIT   = 0;
   localparam int unsigned CGW_STATUS_ACTIVE_BIT = 0;
   localparam int unsigned CGW_SSC_EN_BIT        = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CGW_RST_MODE  = 8'h01;
   localparam logic [7:0] CGW_RST_SSC   = 8'h00;
   localparam logic [7:0] CGW_RST_OE    = 8'h0f;
   localparam logic [7:0] CGW_RST_INSEL = 8'h00;
   localparam logic [7:0] CGW_RST_DIV   = 8'h01;
   localparam logic [7:0] CGW_RST_CFG   = 8'h00;

   // ----------------------------------------------------------------
   // operating mode, gray coded along ready -> start -> active
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      CGW_READY  = 2'b00,
      CGW_START  = 2'b01,
      CGW_ACTIVE = 2'b11
   } cgw_mode_t;

endpackage : cgw_pkg

// [src/cgw_clk_div.sv]
// one output clock divider with a run gate
// assumes run and half_period come from flip-flops in the same clock domain
module cgw_clk_div
   import cgw_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       run,
   input  wire logic [7:0] half_period,
   output logic            clk_o
);

   logic [7:0] cnt_ff;
   logic       clk_ff;

   // ----------------------------------------------------------------
   // divider: high and low phases last half_period+1 cycles each
   // ----------------------------------------------------------------
   // stopping forces the pin low so a restart always begins on a rising edge
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= 8'h00;
         clk_ff <= 1'b0;
      end
      else if (!run)
      begin
         cnt_ff <= 8'h00; // RQ4
         clk_ff <= 1'b0;  // RQ1
      end
      else if (cnt_ff == half_period)
      begin
         cnt_ff <= 8'h00;
         clk_ff <= ~clk_ff;
      end
      else
      begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   assign clk_o = clk_ff;

endmodule : cgw_clk_div

// [src/cgw_write_gate.sv]
// register bank with mode-gated writes and gated output clocks
// assumes a serial management decoder presents byte writes and reads as one-cycle requests
module cgw_write_gate
   import cgw_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic                   wr_req,
   input  wire logic [CGW_ADDR_W-1:0]  wr_addr,
   input  wire logic [CGW_DATA_W-1:0]  wr_data,
   output logic                        wr_ack,
   output logic                        wr_blocked,
   input  wire logic                   rd_req,
   input  wire logic [CGW_ADDR_W-1:0]  rd_addr,
   output logic [CGW_DATA_W-1:0]       rd_data,
   output logic                        rd_ack,
   output logic [CGW_NUM_OUT-1:0]      clk_out,
   output logic                        mode_active,
   output logic                        ssc_en,
   output logic [CGW_INSEL_W-1:0]      in_sel
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   cgw_mode_t             mode_ff;
   cgw_mode_t             nxt_mode;
   logic [7:0]            regs_ff [CGW_NUM_REGS];
   logic [7:0]            applied_div_ff [CGW_NUM_OUT];
   logic                  wr_ack_ff;
   logic                  wr_blocked_ff;
   logic [7:0]            rd_data_ff;
   logic                  rd_ack_ff;
   logic                  ungated;
   logic                  wr_ok;
   logic                  active_req;
   logic [CGW_NUM_OUT-1:0] run;

   // reset value of each register entry
   function automatic logic [7:0] cgw_rst_val(input logic [3:0] idx);
      logic [7:0] val;
      val = CGW_RST_CFG;
      if (idx == CGW_OFS_MODE)
         val = CGW_RST_MODE;
      else if (idx == CGW_OFS_SSC)
         val = CGW_RST_SSC;
      else if (idx == CGW_OFS_OE)
         val = CGW_RST_OE;
      else if (idx == CGW_OFS_INSEL)
         val = CGW_RST_INSEL;
      else if ((idx >= CGW_OFS_DIV_BASE) && (idx < CGW_OFS_DIV_BASE + 4'(CGW_NUM_OUT)))
         val = CGW_RST_DIV;
      return val;
   endfunction : cgw_rst_val

   // ----------------------------------------------------------------
   // write gating
   // ----------------------------------------------------------------
   // these four entries stay writable in every mode
   assign ungated = (wr_addr == CGW_OFS_MODE) ||
                    (wr_addr == CGW_OFS_SSC)  ||
                    (wr_addr == CGW_OFS_OE)   ||
                    (wr_addr == CGW_OFS_INSEL); // RQ6

   // the start state counts as not ready, so nothing slips in while the copy is taken
   assign wr_ok = wr_req &&
                  (wr_addr != CGW_OFS_STATUS) &&
                  (ungated || (mode_ff == CGW_READY)); // RQ2 RQ3

   assign active_req = regs_ff[CGW_OFS_MODE][CGW_MODE_ACTIVE_BIT];

   // ----------------------------------------------------------------
   // register storage, one entry per generate step
   // ----------------------------------------------------------------
   // the status index has a flop here too but it is never written and never read
   for (genvar g = 0; g < CGW_NUM_REGS; g++)
   begin : g_reg
      localparam logic [3:0] IDX = 4'(g);
      always_ff @(posedge core_clk or negedge rst_b)
      begin
         if (!rst_b)
            regs_ff[g] <= cgw_rst_val(IDX);
         else if (wr_ok && (wr_addr == IDX))
            regs_ff[g] <= wr_data; // RQ2 RQ3 RQ6
      end
   end

   // ----------------------------------------------------------------
   // write answer: every request is acknowledged, taken or not
   // ----------------------------------------------------------------
   // the serial side never stalls, a refused byte is simply dropped
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ack_ff     <= 1'b0;
         wr_blocked_ff <= 1'b0;
      end
      else
      begin
         wr_ack_ff     <= wr_req;           // RQ11
         wr_blocked_ff <= wr_req && !wr_ok; // RQ11
      end
   end

   assign wr_ack     = wr_ack_ff;
   assign wr_blocked = wr_blocked_ff;

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         CGW_READY:
         begin
            if (active_req)
               nxt_mode = CGW_START;
         end
         CGW_START:
         begin
            if (active_req)
               nxt_mode = CGW_ACTIVE;
            else
               nxt_mode = CGW_READY;
         end
         CGW_ACTIVE:
         begin
            if (!active_req)
               nxt_mode = CGW_READY;
         end
         default:
         begin
            nxt_mode = CGW_READY;
         end
      endcase
   end

   // reset leaves the part running on its reset configuration
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         mode_ff <= CGW_ACTIVE;
      else
         mode_ff <= nxt_mode;
   end

   // ----------------------------------------------------------------
   // applied divider copy, taken on the way back to active
   // ----------------------------------------------------------------
   // live edits never reach a running divider; only the start state copies them
   for (genvar o = 0; o < CGW_NUM_OUT; o++)
   begin : g_apply
      localparam logic [3:0] DIDX = CGW_OFS_DIV_BASE + 4'(o);
      always_ff @(posedge core_clk or negedge rst_b)
      begin
         if (!rst_b)
            applied_div_ff[o] <= CGW_RST_DIV;
         else if (mode_ff == CGW_START)
            applied_div_ff[o] <= regs_ff[DIDX]; // RQ5
      end

      // output runs only in active mode and with its enable set
      assign run[o] = (mode_ff == CGW_ACTIVE) && regs_ff[CGW_OFS_OE][o]; // RQ1 RQ4

      cgw_clk_div u_div
      (
         .core_clk    (core_clk),
         .rst_b       (rst_b),
         .run         (run[o]),
         .half_period (applied_div_ff[o]),
         .clk_o       (clk_out[o])
      );
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // status shows the real mode, not the request, so the host sees start as not active
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_data_ff <= 8'h00;
         rd_ack_ff  <= 1'b0;
      end
      else
      begin
         rd_ack_ff <= rd_req;
         if (rd_req)
         begin
            if (rd_addr == CGW_OFS_STATUS)
               rd_data_ff <= {7'h00, (mode_ff == CGW_ACTIVE)}; // RQ7
            else
               rd_data_ff <= regs_ff[rd_addr];
         end
      end
   end

   assign rd_data = rd_data_ff;
   assign rd_ack  = rd_ack_ff;

   // ----------------------------------------------------------------
   // live control outputs
   // ----------------------------------------------------------------
   assign mode_active = (mode_ff == CGW_ACTIVE); // RQ7
   assign ssc_en      = regs_ff[CGW_OFS_SSC][CGW_SSC_EN_BIT];
   assign in_sel      = regs_ff[CGW_OFS_INSEL][CGW_INSEL_W-1:0];

endmodule : cgw_write_gate

// [verification/cgw_write_gate_monitor.sv]
// checker: port-level timing of the write gate
// assumes one clock domain; bound to every cgw_write_gate below
module cgw_write_gate_monitor
   import cgw_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst_b,
   input wire logic                   wr_req,
   input wire logic [CGW_ADDR_W-1:0]  wr_addr,
   input wire logic [CGW_DATA_W-1:0]  wr_data,
   input wire logic                   wr_ack,
   input wire logic                   wr_blocked,
   input wire logic                   rd_req,
   input wire logic [CGW_ADDR_W-1:0]  rd_addr,
   input wire logic [CGW_DATA_W-1:0]  rd_data,
   input wire logic                   rd_ack,
   input wire logic [CGW_NUM_OUT-1:0] clk_out,
   input wire logic                   mode_active,
   input wire logic                   ssc_en,
   input wire logic [CGW_INSEL_W-1:0] in_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   wr_answer_a: assert property (wr_req |=> wr_ack)
      else $error("write not answered");
   status_wr_a: assert property (wr_req && wr_addr == CGW_OFS_STATUS |=> wr_blocked)
      else $error("status write not refused");
   gated_active_a: assert property (wr_req && mode_active && wr_addr >= CGW_OFS_DIV_BASE |=> wr_blocked)
      else $error("gated write taken while active");
   ungated_a: assert property (wr_req && wr_addr inside {4'h0, 4'h2, 4'h3, 4'h4} |=> !wr_blocked)
      else $error("ungated write refused");
   // a two-cycle wait lets the divider flops settle after the mode drop
   clk_stop_a: assert property (!mode_active [*2] |-> clk_out == '0)
      else $error("output toggles outside active");
   rd_answer_a: assert property (rd_req |=> rd_ack)
      else $error("read not answered");
   status_rd_a: assert property (rd_req && rd_addr == CGW_OFS_STATUS |=> rd_data == {7'h0, $past(mode_active)})
      else $error("status read wrong");
   ssc_live_a: assert property (wr_req && wr_addr == CGW_OFS_SSC |=> ssc_en == $past(wr_data[0]))
      else $error("spread enable not live");
   restart_a: assert property (wr_req && wr_addr == CGW_OFS_MODE && wr_data[0] && !mode_active
      |-> ##[2:4] mode_active)
      else $error("no return to active");
   cover property ($fell(mode_active));
   cover property (wr_req ##1 wr_blocked);
   cover property ($rose(mode_active));
endmodule : cgw_write_gate_monitor

bind cgw_write_gate cgw_write_gate_monitor i_cgw_write_gate_monitor (
   .core_clk(core_clk), .rst_b(rst_b), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
   .wr_ack(wr_ack), .wr_blocked(wr_blocked), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
   .rd_ack(rd_ack), .clk_out(clk_out), .mode_active(mode_active), .ssc_en(ssc_en), .in_sel(in_sel)
);

// [verification/cgw_host_model.sv]
// host model: one-cycle write and read requests to the write gate
// assumes its tasks are called from a single bench process
module cgw_host_model
   import cgw_pkg::*;
(
   input  wire logic                  core_clk,
   output logic                       wr_req,
   output logic [CGW_ADDR_W-1:0]      wr_addr,
   output logic [CGW_DATA_W-1:0]      wr_data,
   output logic                       rd_req,
   output logic [CGW_ADDR_W-1:0]      rd_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle lines show the inverse so a stale value never looks live
   initial
   begin
      {wr_req, rd_req} = 2'b00;
      {wr_addr, rd_addr, wr_data} = 16'h5aa5;
   end
   task automatic wr(input logic [CGW_ADDR_W-1:0] a, input logic [CGW_DATA_W-1:0] d);
      @(posedge core_clk);
      #1;
      {wr_req, wr_addr, wr_data} = {1'b1, a, d};
      @(posedge core_clk);
      #1;
      {wr_req, wr_addr, wr_data} = {1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [CGW_ADDR_W-1:0] a);
      @(posedge core_clk);
      #1;
      {rd_req, rd_addr} = {1'b1, a};
      @(posedge core_clk);
      #1;
      {rd_req, rd_addr} = {1'b0, ~a};
   endtask : rd
   // change mode, then confirm it in status before anything else
   task automatic set_mode(input logic act);
      wr(CGW_OFS_MODE, {7'h0, act});
      repeat (3) @(posedge core_clk);
      rd(CGW_OFS_STATUS);
   endtask : set_mode
endmodule : cgw_host_model

// [verification/cgw_write_gate_tb.sv]
// testbench: drives the write gate through the host model
// assumes design, package, checker and host model compiled first
module cgw_write_gate_tb
   import cgw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   core_clk = 1'b0;
   logic                   rst_b = 1'b0;
   // request lines are nets driven by the host model's ports
   wire logic                  wr_req, rd_req;
   wire logic [CGW_ADDR_W-1:0] wr_addr, rd_addr;
   wire logic [CGW_DATA_W-1:0] wr_data;
   logic                   wr_ack, wr_blocked, rd_ack, mode_active, ssc_en;
   logic [CGW_DATA_W-1:0]  rd_data, v, div;
   logic [CGW_NUM_OUT-1:0] clk_out;
   logic [CGW_INSEL_W-1:0] in_sel;
   logic [7:0]             msk[3] = '{8'h01, 8'h0f, 8'h03};
   logic                   qw[$];
   logic [7:0]             qr[$];
   int                     n_mismatch = 0;
   int                     compares = 0;
   int                     cycles = 0;
   int                     hi;
   always #10 core_clk = ~core_clk;
   cgw_write_gate i_cgw_write_gate (.core_clk(core_clk), .rst_b(rst_b), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack), .wr_blocked(wr_blocked), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .clk_out(clk_out),
      .mode_active(mode_active), .ssc_en(ssc_en), .in_sel(in_sel));
   cgw_host_model i_cgw_host_model (.core_clk(core_clk), .wr_req(wr_req), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr));
   task automatic fail(input string m);
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task automatic chk(input logic c, input string m);
      compares++;
      if (c !== 1'b1) fail(m);
   endtask : chk
   task automatic wr_chk(input logic [3:0] a, input logic [7:0] d, input logic blk);
      qw.push_back(blk);
      i_cgw_host_model.wr(a, d);
   endtask : wr_chk
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      qr.push_back(e);
      i_cgw_host_model.rd(a);
   endtask : rd_chk
   task automatic tally_and_finish();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // answers are settled by the falling edge; the oldest note is the one due
   always @(negedge core_clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         fail("timeout");
         tally_and_finish();
      end
      else
      begin
         if (wr_ack === 1'b1)
            chk(qw.size() > 0 && wr_blocked === qw.pop_front(), "write refusal");
         if (rd_ack === 1'b1)
            chk(qr.size() > 0 && rd_data === qr.pop_front(), "read data");
      end
   end
   initial
   begin
      void'($urandom(32'hebc3));
      repeat (4) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      rd_chk(CGW_OFS_STATUS, 8'h01);
      // active: gated places refuse and keep their reset contents
      for (int a = 5; a < 16; a++)
      begin
         wr_chk(a[3:0], 8'($urandom), 1'b1);
         rd_chk(a[3:0], a < 9 ? CGW_RST_DIV : CGW_RST_CFG);
      end
      wr_chk(CGW_OFS_STATUS, 8'h00, 1'b1);
      // ungated places stay open, so active mode is no guard against strays
      foreach (msk[i])
      begin
         v = 8'($urandom) & msk[i];
         wr_chk(4'(i + 2), v, 1'b0);
         rd_chk(4'(i + 2), v);
         // the live pins must follow the ungated entries by the time the read-back of the same entry is done
         if (i == 0)
            chk(ssc_en === v[0], "spread enable not live");
         else if (i == 1)
            chk((clk_out & ~v[3:0]) === '0, "disabled output runs");
         else
            chk(in_sel === v[1:0], "input select not live");
      end
      wr_chk(CGW_OFS_OE, CGW_RST_OE, 1'b0);
      qw.push_back(1'b0);
      qr.push_back(8'h00);
      i_cgw_host_model.set_mode(1'b0);
      chk(clk_out === '0 && mode_active === 1'b0, "outputs run in ready");
      div = 8'(1 + $urandom % 3);
      for (int a = 5; a < 16; a++)
      begin
         wr_chk(a[3:0], div, 1'b0);
         rd_chk(a[3:0], div);
      end
      qw.push_back(1'b0);
      qr.push_back(8'h01);
      i_cgw_host_model.set_mode(1'b1);
      chk(mode_active === 1'b1, "active not reached");
      // high phase of output 0 must follow the half period written in ready
      @(posedge clk_out[0]);
      hi = 0;
      while (clk_out[0] === 1'b1)
      begin
         @(posedge core_clk);
         #1;
         hi++;
      end
      chk(hi == int'(div) + 1, "restart period");
      // mid-run reset must bring back the reset configuration and active mode
      @(posedge core_clk);
      #1;
      rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      chk(mode_active === 1'b1 && ssc_en === 1'b0 && in_sel === '0, "reset state");
      rd_chk(CGW_OFS_DIV_BASE, CGW_RST_DIV);
      rd_chk(CGW_OFS_STATUS, 8'h01);
      repeat (2) @(posedge core_clk);
      chk(qw.size() == 0 && qr.size() == 0, "missing answers");
      tally_and_finish();
   end
endmodule : cgw_write_gate_tb
